// ===== hdl/link_pm_map.vh
`ifndef LINK_PM_MAP_VH
`define LINK_PM_MAP_VH
// Register indices (byte address = offset)
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_ACTION 8'h08
`define REG_CMD 8'h0C
`define REG_MODE_BASE 8'h10
// Control field positions
`define CTRL_DYN_EN 0
`define CTRL_GEN3 1
`define CTRL_REFRESH_EN 2
`define CTRL_MODE_LOCK 3
// Command field positions
`define CMD_GO 0
`define CMD_REFRESH 1
// Reset values
`define ACTION_RESET 4'h0
`define CTRL_RESET 32'h0000_0000
// Timing in cycles, and mode table depth in entries
`define STOP_HOLD_CYCLES 16'h0040
`define REFRESH_HOLD_CYCLES 16'h0020
`define MODE_ENTRIES 16
`endif

// ===== hdl/link_mode_mem.v
`timescale 1ns/1ps
`default_nettype none
module link_mode_mem (
    input wire mclk,
    input wire we,
    input wire [3:0] waddr,
    input wire [31:0] wdata,
    input wire [3:0] raddr,
    output reg [31:0] rdata
);
    reg [31:0] mem [0:15];
    always @(posedge mclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// ===== hdl/central_link_power_controller.v
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "link_pm_map.vh"
module central_link_power_controller (
    input wire mclk,
    input wire nrst,
    input wire warm_rst_n,
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    input wire link_clk,
    input wire clock_stop_active,
    input wire int_pending_msg,
    input wire ext_stop_req,
    input wire ext_clock_stop_req,
    input wire link_wake_request_n,
    output reg link_stop_n,
    output wire clock_stop_request,
    output reg wake_system,
    output reg [3:0] link_action_code,
    output reg [31:0] active_mode,
    output reg seq_busy
);
    localparam ST_IDLE = 2'b00;
    localparam ST_LOAD = 2'b01;
    localparam ST_STOP = 2'b10;
    localparam ST_REFR = 2'b11;

    // Two-stage synchronisers for pin inputs
    wire [5:0] pin_in;
    wire [5:0] pin_sync;
    reg link_clk_d;
    wire cs_act = pin_sync[0];
    wire ip_msg = pin_sync[1];
    wire x_stop = pin_sync[2];
    wire x_cs = pin_sync[3];
    wire wake_req = pin_sync[4];
    wire lclk = pin_sync[5];
    wire lclk_rise = lclk & ~link_clk_d;
    reg ip_msg_d;
    wire ip_pulse = ip_msg & ~ip_msg_d;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [15:0] cnt;
    reg stop_clk_flag;
    reg dyn_en;
    reg gen3;
    reg refresh_en;
    reg [3:0] pend_code;
    reg code_dirty;
    reg go_pend;
    reg refr_pend;
    wire [31:0] mem_rdata;

    function is_mode_addr;
        input [7:0] a;
        begin
            is_mode_addr = (a >= `REG_MODE_BASE) && (a < `REG_MODE_BASE + 8'h40) &&
                (a[1:0] == 2'b00);
        end
    endfunction

    // Register address match
    function reg_hit;
        input [7:0] a;
        input [7:0] off;
        begin
            reg_hit = (a == off);
        end
    endfunction

    // Write strobes per register
    wire mode_we = wr & is_mode_addr(addr);
    wire [7:0] mode_off = addr - `REG_MODE_BASE;
    wire ctrl_we = wr & reg_hit(addr, `REG_CTRL);
    wire action_we = wr & reg_hit(addr, `REG_ACTION) & dyn_en;
    wire cmd_we = wr & reg_hit(addr, `REG_CMD);
    wire refr_start = (state == ST_IDLE) && !go_pend && refr_pend && lclk_rise;

    // Mode table, read address follows the sequencer
    link_mode_mem u_mem (
        .mclk(mclk),
        .we(mode_we),
        .waddr(mode_off[5:2]),
        .wdata(wdata),
        .raddr(state == ST_IDLE ? pend_code : link_action_code),
        .rdata(mem_rdata)
    );

    assign pin_in = {link_clk, ~link_wake_request_n, ext_clock_stop_req, ext_stop_req,
        int_pending_msg, clock_stop_active};

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
            reg stage1;
            reg stage2;
            always @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    stage1 <= 1'b0;
                    stage2 <= 1'b0;
                end else begin
                    stage1 <= pin_in[gi];
                    stage2 <= stage1;
                end
            end
            assign pin_sync[gi] = stage2;
        end
    endgenerate

    // Edge detectors on the synchronised pins
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            link_clk_d <= 1'b0;
            ip_msg_d <= 1'b0;
        end else begin
            link_clk_d <= lclk;
            ip_msg_d <= ip_msg;
        end
    end

    // Stop-clock flag and pending-interrupt handling
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            stop_clk_flag <= 1'b0;
            wake_system <= 1'b0;
        end else begin
            stop_clk_flag <= cs_act;
            if (stop_clk_flag && ip_pulse) begin
                wake_system <= 1'b1;
            end else if (!stop_clk_flag) begin
                wake_system <= 1'b0;
            end
        end
    end

    // Stop-clock requests from outside are held off during a sequence
    assign clock_stop_request = x_cs & ~seq_busy;

    // Dynamic config enable: software sets it, only nrst or warm reset clears it
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dyn_en <= 1'b0;
        end else if (!warm_rst_n) begin
            dyn_en <= 1'b0;
        end else if (ctrl_we) begin
            dyn_en <= dyn_en | wdata[`CTRL_DYN_EN];
        end
    end

    // Link rate and refresh enable
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            gen3 <= 1'b0;
            refresh_en <= 1'b0;
        end else if (warm_rst_n && ctrl_we) begin
            gen3 <= wdata[`CTRL_GEN3];
            refresh_en <= wdata[`CTRL_REFRESH_EN];
        end
    end

    // Pending action code waits for the next control sequence
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pend_code <= `ACTION_RESET;
            code_dirty <= 1'b0;
        end else if (!warm_rst_n) begin
            pend_code <= `ACTION_RESET;
            code_dirty <= 1'b0;
        end else if (action_we) begin
            pend_code <= wdata[3:0];
            code_dirty <= 1'b1;
        end else if (state == ST_LOAD) begin
            code_dirty <= 1'b0;
        end
    end

    // Control command waits for an idle sequencer
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            go_pend <= 1'b0;
        end else if (!warm_rst_n) begin
            go_pend <= 1'b0;
        end else if (cmd_we && wdata[`CMD_GO]) begin
            go_pend <= 1'b1;
        end else if (state == ST_IDLE) begin
            go_pend <= 1'b0;
        end
    end

    // Refresh command taken only at gen3 with refresh enabled
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            refr_pend <= 1'b0;
        end else if (!warm_rst_n) begin
            refr_pend <= 1'b0;
        end else if (cmd_we && wdata[`CMD_REFRESH] && gen3 && refresh_en) begin
            refr_pend <= 1'b1;
        end else if (refr_start) begin
            refr_pend <= 1'b0;
        end
    end

    // Next state
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (go_pend) begin
                    next_state = ST_LOAD;
                end else if (refr_pend && lclk_rise) begin
                    next_state = ST_REFR;
                end
            end
            ST_LOAD: next_state = ST_STOP;
            ST_STOP: begin
                if (cnt == 16'h0000 && wake_req == 1'b1) begin
                    next_state = ST_IDLE;
                end
            end
            ST_REFR: begin
                if (cnt == 16'h0000) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // Sequencer state and busy flag
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state <= ST_IDLE;
            seq_busy <= 1'b0;
        end else if (!warm_rst_n) begin
            state <= ST_IDLE;
            seq_busy <= 1'b0;
        end else begin
            state <= next_state;
            seq_busy <= (next_state != ST_IDLE);
        end
    end

    // Hold counter for the link stop window
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 16'h0000;
        end else if (!warm_rst_n) begin
            cnt <= 16'h0000;
        end else if (next_state == ST_LOAD) begin
            cnt <= `STOP_HOLD_CYCLES;
        end else if (next_state == ST_REFR && state == ST_IDLE) begin
            cnt <= `REFRESH_HOLD_CYCLES;
        end else if (cnt != 16'h0000) begin
            cnt <= cnt - 16'h0001;
        end
    end

    // Action code changes only as the link stops, or on reset
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            link_action_code <= `ACTION_RESET;
        end else if (!warm_rst_n) begin
            link_action_code <= `ACTION_RESET;
        end else if (state == ST_LOAD && code_dirty) begin
            link_action_code <= pend_code;
        end
    end

    // Mode entry taken two cycles into the stop window
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            active_mode <= 32'h0000_0000;
        end else if (warm_rst_n && state == ST_STOP && cnt == `STOP_HOLD_CYCLES - 16'h0002) begin
            active_mode <= mem_rdata;
        end
    end

    // Sole driver of link stop; outside stops wait while busy
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            link_stop_n <= 1'b1;
        end else if (!warm_rst_n) begin
            link_stop_n <= 1'b1;
        end else if (next_state == ST_STOP || next_state == ST_REFR) begin
            link_stop_n <= 1'b0;
        end else if (next_state == ST_IDLE && x_stop && !seq_busy) begin
            link_stop_n <= 1'b0;
        end else begin
            link_stop_n <= 1'b1;
        end
    end

    // Register read port
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata <= 32'h0000_0000;
        end else if (rd) begin
            case (addr)
                `REG_CTRL: rdata <= {29'h0, refresh_en, gen3, dyn_en};
                `REG_STATUS: rdata <= {24'h0, ~link_stop_n, seq_busy, wake_system,
                    stop_clk_flag, state, refr_pend, go_pend};
                `REG_ACTION: rdata <= {24'h0, link_action_code, pend_code};
                default: rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

// ===== tb/link_pm_chk.sv
`timescale 1ns/1ps
`default_nettype none
module link_pm_chk (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic warm_rst_n,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire logic clock_stop_active,
    input wire logic int_pending_msg,
    input wire logic link_stop_n,
    input wire logic clock_stop_request,
    input wire logic wake_system,
    input wire logic [3:0] link_action_code,
    input wire logic seq_busy
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_in_stop;
        clock_stop_active [*6];
    endsequence
    sequence s_out_stop;
        !clock_stop_active [*8];
    endsequence
    property p_start;
        $rose(seq_busy) |-> ##[0:2] !link_stop_n;
    endproperty
    property p_hold;
        $fell(link_stop_n) && warm_rst_n |=> !link_stop_n [*8];
    endproperty
    property p_gate;
        seq_busy |-> !clock_stop_request;
    endproperty
    property p_wake;
        s_in_stop ##0 $rose(int_pending_msg) |-> ##[1:6] wake_system;
    endproperty
    property p_drop;
        s_out_stop |-> !wake_system;
    endproperty
    property p_code_rst;
        !warm_rst_n |=> link_action_code == 4'h0;
    endproperty
    property p_code_stop;
        $changed(link_action_code) && $past(warm_rst_n) |-> !link_stop_n;
    endproperty
    property p_rd_idle;
        !$past(rd) |-> rdata == 32'h0000_0000;
    endproperty
    a_start: assert property (p_start) else $error("no link stop at start");
    a_hold: assert property (p_hold) else $error("link stop too short");
    a_gate: assert property (p_gate) else $error("clock stop passed");
    a_wake: assert property (p_wake) else $error("no wake");
    a_drop: assert property (p_drop) else $error("wake outside stop");
    a_code_rst: assert property (p_code_rst) else $error("code not cleared");
    a_code_stop: assert property (p_code_stop) else $error("code off stop");
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
endmodule
bind central_link_power_controller link_pm_chk u_chk (.mclk(mclk), .nrst(nrst),
    .warm_rst_n(warm_rst_n), .rd(rd), .rdata(rdata), .clock_stop_active(clock_stop_active),
    .int_pending_msg(int_pending_msg), .link_stop_n(link_stop_n),
    .clock_stop_request(clock_stop_request), .wake_system(wake_system),
    .link_action_code(link_action_code), .seq_busy(seq_busy));
`default_nettype wire

// ===== tb/link_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module link_far_side (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic link_stop_n,
    input wire logic [7:0] wake_dly,
    input wire logic send_int,
    output logic link_wake_request_n,
    output logic int_pending_msg
);
    logic [7:0] cnt;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 8'h00;
            link_wake_request_n <= 1'b1;
            int_pending_msg <= 1'b0;
        end else begin
            int_pending_msg <= send_int;
            if (link_stop_n) begin
                cnt <= 8'h00;
                link_wake_request_n <= 1'b1;
            end else if (cnt == wake_dly) begin
                link_wake_request_n <= 1'b0;
            end else begin
                cnt <= cnt + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/link_power_mgmt_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "link_pm_map.vh"
module link_power_mgmt_controller_tb;
    logic mclk = 1'b0, link_clk = 1'b0, nrst = 1'b0, warm_rst_n = 1'b1;
    logic wr = 1'b0, rd = 1'b0, rd_d = 1'b0, send_int = 1'b0, clock_stop_active = 1'b0;
    logic ext_stop_req = 1'b0, ext_clock_stop_req = 1'b0;
    logic [7:0] addr = 8'h00, wake_dly = 8'h02;
    logic [31:0] wdata = 32'h0000_0000, seed = 32'h0000_f8c3;
    logic link_wake_request_n, int_pending_msg, link_stop_n, clock_stop_request;
    logic wake_system, seq_busy;
    logic [3:0] link_action_code, code;
    logic [31:0] rdata, active_mode;
    logic [31:0] mode [16];
    logic [63:0] exp_q [$];
    logic [63:0] e;
    int err_count = 0, n_tests = 0;
    int n_busy = 0;
    always #5 mclk = ~mclk;
    always #40 link_clk = ~link_clk;
    central_link_power_controller dut (.mclk(mclk), .nrst(nrst), .warm_rst_n(warm_rst_n),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link_clk(link_clk),
        .clock_stop_active(clock_stop_active), .int_pending_msg(int_pending_msg),
        .ext_stop_req(ext_stop_req), .ext_clock_stop_req(ext_clock_stop_req),
        .link_wake_request_n(link_wake_request_n), .link_stop_n(link_stop_n),
        .clock_stop_request(clock_stop_request), .wake_system(wake_system),
        .link_action_code(link_action_code), .active_mode(active_mode), .seq_busy(seq_busy));
    link_far_side far (.mclk(mclk), .nrst(nrst), .link_stop_n(link_stop_n),
        .wake_dly(wake_dly), .send_int(send_int),
        .link_wake_request_n(link_wake_request_n), .int_pending_msg(int_pending_msg));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic chk(input logic [31:0] m, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if ((got & m) !== (ex & m)) begin
            err_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, ex & m, got & m);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ex);
        exp_q.push_back({m, ex});
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        if (rd_d) begin
            e = exp_q.pop_front();
            chk(e[63:32], e[31:0], rdata);
        end
        rd_d <= rd;
    end
    initial begin
        cyc(3);
        nrst <= 1'b1;
        rd_reg(`REG_CTRL, 32'hffff_ffff, 32'h0000_0000);
        rd_reg(`REG_ACTION, 32'hffff_ffff, 32'h0000_0000);
        rd_reg(8'hf0, 32'hffff_ffff, 32'h0000_0000);
        seed = xs(seed);
        code = seed[3:0] | 4'h1;
        wr_reg(`REG_ACTION, {28'h000_0000, code});
        rd_reg(`REG_ACTION, 32'h0000_00ff, 32'h0000_0000);
        for (int i = 0; i < 16; i++) begin
            seed = xs(seed);
            mode[i] = seed;
            wr_reg(`REG_MODE_BASE + 8'(4 * i), seed);
        end
        wr_reg(`REG_CTRL, 32'h0000_0001);
        wr_reg(`REG_CTRL, 32'h0000_0000);
        rd_reg(`REG_CTRL, 32'h0000_0001, 32'h0000_0001);
        wr_reg(`REG_ACTION, {28'h000_0000, code});
        rd_reg(`REG_ACTION, 32'h0000_00ff, {28'h000_0000, code});
        for (int j = 0; j < 2; j++) begin
            wake_dly <= (j == 0) ? 8'h02 : 8'h64;
            wr_reg(`REG_CMD, 32'h0000_0001);
            cyc(4);
            ext_clock_stop_req <= 1'b1;
            ext_stop_req <= 1'b1;
            cyc(10);
            chk(32'h0000_0001, 32'h0000_0000, {31'h0, clock_stop_request});
            chk(32'h0000_0001, 32'h0000_0000, {31'h0, link_stop_n});
            ext_clock_stop_req <= 1'b0;
            ext_stop_req <= 1'b0;
            while (seq_busy !== 1'b0) @(posedge mclk);
            rd_reg(`REG_ACTION, 32'h0000_00f0, {24'h00_0000, code, 4'h0});
            chk(32'hffff_ffff, mode[code], active_mode);
        end
        warm_rst_n <= 1'b0;
        cyc(2);
        warm_rst_n <= 1'b1;
        rd_reg(`REG_ACTION, 32'h0000_00ff, 32'h0000_0000);
        rd_reg(`REG_CTRL, 32'h0000_0001, 32'h0000_0000);
        for (int k = 0; k < 2; k++) begin
            clock_stop_active <= (k == 0);
            cyc(10);
            send_int <= 1'b1;
            cyc(2);
            send_int <= 1'b0;
            cyc(8);
            rd_reg(`REG_STATUS, 32'h0000_0030, (k == 0) ? 32'h0000_0030 : 32'h0);
        end
        ext_clock_stop_req <= 1'b1;
        ext_stop_req <= 1'b1;
        cyc(4);
        chk(32'h0000_0001, 32'h0000_0001, {31'h0, clock_stop_request});
        chk(32'h0000_0001, 32'h0000_0000, {31'h0, link_stop_n});
        cyc(8);
        ext_clock_stop_req <= 1'b0;
        ext_stop_req <= 1'b0;
        cyc(6);
        chk(32'h0000_0001, 32'h0000_0001, {31'h0, link_stop_n});
        chk(32'h0000_0001, 32'h0000_0000, {31'h0, clock_stop_request});
        wr_reg(`REG_CMD, 32'h0000_0002);
        rd_reg(`REG_STATUS, 32'h0000_0042, 32'h0000_0000);
        wr_reg(`REG_CTRL, 32'h0000_0006);
        wr_reg(`REG_CMD, 32'h0000_0002);
        while (seq_busy !== 1'b1) @(posedge mclk);
        while (seq_busy === 1'b1) begin
            n_busy++;
            @(posedge mclk);
        end
        chk(32'h0000_ffff, {16'h0000, `REFRESH_HOLD_CYCLES} + 32'h0000_0001, n_busy);
        cyc(4);
        end_sim;
    end
    initial begin
        #100000;
        err_count++;
        end_sim;
    end
endmodule
`default_nettype wire
